// ==== logic/temp_limit_pkg.sv ====
// package: register map, field positions, reset values and link constants
// assumes: shared by the register bank and its limit trackers, one 40 MHz clock
package temp_limit_pkg;

  // ==========================================================
  // register addresses
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_CONFIG = 3'h1;
  localparam logic [2:0] ADDR_RESULT = 3'h2;
  localparam logic [2:0] ADDR_IDENT  = 3'h3;
  localparam logic [2:0] ADDR_CRIT   = 3'h4;
  localparam logic [2:0] ADDR_HYST   = 3'h5;
  localparam logic [2:0] ADDR_HIGH   = 3'h6;
  localparam logic [2:0] ADDR_LOW    = 3'h7;

  // ==========================================================
  // reset values
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [15:0] CRIT_RST   = 16'h4980;
  localparam logic [3:0]  HYST_RST   = 4'h5;
  localparam logic [15:0] HIGH_RST   = 16'h2000;
  localparam logic [15:0] LOW_RST    = 16'h0500;
  localparam logic        RES_RST    = 1'b0;
  localparam logic        RDY_RST    = 1'b1;

  // ==========================================================
  // field positions
  localparam int RDY_POS       = 7;
  localparam int RES_POS       = 7;
  localparam int FLAG_CRIT_POS = 2;
  localparam int FLAG_HIGH_POS = 1;
  localparam int FLAG_LOW_POS  = 0;
  localparam int FLAG_BITS     = 3;
  localparam int HYST_BITS     = 4;
  localparam int HYST_SHIFT    = 7;
  localparam int ID_REV_BITS   = 3;
  localparam int ID_MAKER_BITS = 5;

  // ==========================================================
  // serial command byte
  localparam int          CMD_BITS     = 8;
  localparam int          CMD_RW_POS   = 6;
  localparam int          CMD_ADDR_LSB = 3;
  localparam logic [7:0]  CMD_ZERO_MSK = 8'h87;
  localparam logic [5:0]  IFACE_ONES   = 6'h20;

  // ==========================================================
  // limit slots of the tracker array
  localparam int LIM_LOW  = 0;
  localparam int LIM_HIGH = 1;
  localparam int LIM_CRIT = 2;
  localparam int LIM_NUM  = 3;

  typedef enum logic [2:0] {
    PH_CMD  = 3'b001,
    PH_DATA = 3'b010,
    PH_SKIP = 3'b100
  } phase_t;

  // sixteen-bit registers carry two data bytes, the rest one
  function automatic logic reg_is_wide(input logic [2:0] addr);
    reg_is_wide = (addr == ADDR_RESULT) || (addr == ADDR_CRIT) ||
                  (addr == ADDR_HIGH) || (addr == ADDR_LOW);
  endfunction

endpackage

// ==== logic/limit_tracker.sv ====
// limit tracker: one setpoint compare with hysteresis release
// assumes: sample words and limits in the same aligned 1/128 degree units
`timescale 1ns/1ps
`default_nettype none

module limit_tracker #(
  parameter bit UNDER = 1'b0
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        clear,
  input  wire logic [15:0] sample,
  input  wire logic        sample_valid,
  input  wire logic [15:0] limit,
  input  wire logic [3:0]  hyst,
  output logic             beyond,
  output logic             active
);
  import temp_limit_pkg::*;

  typedef struct packed {
    logic active;
  } trk_t;

  trk_t               q;
  trk_t               d;
  logic signed [16:0] s17;
  logic signed [16:0] lim17;
  logic signed [16:0] hyst17;
  logic signed [16:0] rel17;

  // ==========================================================
  // compare
  always_comb begin
    s17    = {sample[15], sample};
    lim17  = {limit[15], limit};
    hyst17 = 17'({hyst, 7'h00});
    rel17  = UNDER ? (lim17 + hyst17) : (lim17 - hyst17);
    beyond = UNDER ? (s17 < lim17) : (s17 > lim17);
    d      = q;
    if (clear) begin
      d.active = 1'b0;
    end else if (sample_valid) begin
      if (q.active) begin
        // stays set until the sample passes the release threshold
        d.active = UNDER ? !(s17 > rel17) : !(s17 < rel17);
      end else begin
        d.active = beyond;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign active = q.active;

endmodule // limit_tracker

`default_nettype wire

// ==== logic/temp_limit_register_bank.sv ====
// temperature register bank with serial register port and limit alarms
// assumes: conversion words arrive on sys_clk; serial pins are asynchronous
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - result register at 0x02 holds latest temperature
// - 13-bit mode: bits 2..0 are alarm flags
// - resolution bit set: bits 2..0 are low temperature
// - low flag set when below low limit
// - high flag set when above high limit
// - critical flag set when above critical limit
// - bit 15 sign, bits 14..3 magnitude, reset zero
// - id register 0x03: maker and revision fields
// - critical limit at 0x04 drives critical pin
// - critical limit resets to 0x4980, signed
// - hysteresis at 0x05 uses four low bits
// - hysteresis 0..15 degrees, resets to 5
// - release: limit minus or plus hysteresis
// - high limit at 0x06 drives interrupt pin
// - high limit resets to 0x2000
// - low limit at 0x07 drives interrupt pin
// - low limit resets to 0x0500
// - setpoints compared as signed two's complement
// - ready bit high on result read, low on result
// - config bit 7: 0 13-bit, 1 16-bit
module temp_limit_register_bank #(
  parameter logic [4:0] MAKER_CODE = 5'h0a, // arbitrary value
  parameter logic [2:0] REV_CODE   = 3'h1,  // arbitrary value
  parameter int         ONES_RESET = int'(temp_limit_pkg::IFACE_ONES)
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [15:0] conv_data,
  input  wire logic        conv_valid,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  output logic             dout,
  output logic             dout_oe,
  output logic             critical_alarm_out,
  output logic             critical_alarm_oe,
  output logic             int_out,
  output logic             int_oe
);
  import temp_limit_pkg::*;

  if (ONES_RESET < 8 || ONES_RESET > 63) begin : g_bad_ones
    $error("ONES_RESET must lie in 8..63");
  end

  typedef struct packed {
    // pin synchronisers
    logic        sclk_s1;
    logic        sclk_s2;
    logic        sclk_p;
    logic        cs_s1;
    logic        cs_s2;
    logic        din_s1;
    logic        din_s2;
    // serial engine
    phase_t      phase;
    logic [4:0]  cnt;
    logic [15:0] sh;
    logic [2:0]  addr;
    logic        rw;
    logic        load;
    logic [15:0] out_sh;
    logic        dout;
    logic        dout_oe;
    logic [5:0]  ones;
    // registers
    logic        res16;
    logic        rdy;
    logic [15:0] result;
    logic [15:0] crit;
    logic [3:0]  hyst;
    logic [15:0] high;
    logic [15:0] low;
    // pins
    logic        crit_oe;
    logic        int_oe;
    logic        crit_lvl;
    logic        int_lvl;
  } bank_t;

  localparam bank_t BANK_RST = '{
    sclk_s1: 1'b1, sclk_s2: 1'b1, sclk_p: 1'b1,
    cs_s1: 1'b1, cs_s2: 1'b1, din_s1: 1'b0, din_s2: 1'b0,
    phase: PH_CMD, cnt: 5'h00, sh: 16'h0000, addr: 3'h0, rw: 1'b0,
    load: 1'b0, out_sh: 16'h0000, dout: 1'b0, dout_oe: 1'b0, ones: 6'h00,
    res16: RES_RST, rdy: RDY_RST, result: RESULT_RST, crit: CRIT_RST,
    hyst: HYST_RST, high: HIGH_RST, low: LOW_RST,
    crit_oe: 1'b0, int_oe: 1'b0, crit_lvl: 1'b0, int_lvl: 1'b0
  };

  localparam logic [5:0] ONES_LAST = 6'(ONES_RESET - 1);

  bank_t             q;
  bank_t             d;
  logic              iface_rst;
  logic [15:0]       sample;
  logic [15:0]       limits  [LIM_NUM];
  logic [LIM_NUM-1:0] beyond;
  logic [LIM_NUM-1:0] active;
  logic [15:0]       rd_data;
  logic              rise;
  logic              fall;
  logic [7:0]        cmd;
  logic [15:0]       wdata;
  logic              last_bit;

  // read view of a register
  function automatic logic [15:0] read_reg(input bank_t s, input logic [2:0] a,
                                           input logic [4:0] maker,
                                           input logic [2:0] rev);
    unique case (a)
      ADDR_STATUS: read_reg = {8'h00, s.rdy, 7'h00};
      ADDR_CONFIG: read_reg = {8'h00, s.res16, 7'h00};
      ADDR_RESULT: read_reg = s.result;
      ADDR_IDENT:  read_reg = {8'h00, maker, rev};
      ADDR_CRIT:   read_reg = s.crit;
      ADDR_HYST:   read_reg = {12'h000, s.hyst};
      ADDR_HIGH:   read_reg = s.high;
      ADDR_LOW:    read_reg = s.low;
    endcase
  endfunction

  // ==========================================================
  // aligned sample and limit trackers
  always_comb begin
    // 13-bit mode drops the three finest bits so compares stay aligned
    sample = q.res16 ? conv_data : {conv_data[15:FLAG_BITS], 3'h0};
    limits[LIM_LOW]  = q.low;
    limits[LIM_HIGH] = q.high;
    limits[LIM_CRIT] = q.crit;
  end

  // pins follow comparator behaviour only; no interrupt-mode latch
  genvar gi;
  generate
    for (gi = 0; gi < LIM_NUM; gi++) begin : g_lim
      limit_tracker #(
        .UNDER (gi == LIM_LOW)
      ) u_trk (
        .sys_clk      (sys_clk),
        .rstn         (rstn),
        .clear        (iface_rst),
        .sample       (sample),
        .sample_valid (conv_valid),
        .limit        (limits[gi]),
        .hyst         (q.hyst),
        .beyond       (beyond[gi]),
        .active       (active[gi])
      );
    end
  endgenerate

  // ==========================================================
  // serial engine and registers
  always_comb begin
    d        = q;
    rise     = q.sclk_s2 & ~q.sclk_p;
    fall     = ~q.sclk_s2 & q.sclk_p;
    cmd      = {q.sh[6:0], q.din_s2};
    wdata    = reg_is_wide(q.addr) ? {q.sh[14:0], q.din_s2} : {8'h00, cmd};
    last_bit = q.cnt == (reg_is_wide(q.addr) ? 5'h0f : 5'h07);
    rd_data  = read_reg(q, q.addr, MAKER_CODE, REV_CODE);
    iface_rst = 1'b0;

    d.sclk_s1 = sclk;
    d.sclk_s2 = q.sclk_s1;
    d.sclk_p  = q.sclk_s2;
    d.cs_s1   = cs_n;
    d.cs_s2   = q.cs_s1;
    d.din_s1  = din;
    d.din_s2  = q.din_s1;
    d.load    = 1'b0;
    d.dout_oe = ~q.cs_s2;

    if (q.load) begin
      // byte registers leave on the upper lane so the shift stays msb first
      d.out_sh = reg_is_wide(q.addr) ? rd_data : {rd_data[7:0], 8'h00};
      if (q.addr == ADDR_RESULT) begin
        d.rdy = 1'b1;
      end
    end

    // deselect aborts a frame, so a cut write never lands
    if (q.cs_s2) begin
      d.phase = PH_CMD;
      d.cnt   = 5'h00;
    end else if (rise) begin
      d.sh  = {q.sh[14:0], q.din_s2};
      d.cnt = q.cnt + 5'h01;
      if (q.din_s2) begin
        d.ones = q.ones + 6'h01;
      end else begin
        d.ones = 6'h00;
      end
      unique case (q.phase)
        PH_CMD: begin
          if (q.cnt == 5'(CMD_BITS - 1)) begin
            d.cnt = 5'h00;
            // a command with a stray fixed bit is ignored to the frame end
            if ((cmd & CMD_ZERO_MSK) != 8'h00) begin
              d.phase = PH_SKIP;
            end else begin
              d.phase = PH_DATA;
              d.addr  = cmd[CMD_ADDR_LSB +: 3];
              d.rw    = cmd[CMD_RW_POS];
              d.load  = cmd[CMD_RW_POS];
            end
          end
        end
        PH_DATA: begin
          if (last_bit) begin
            d.phase = PH_SKIP;
            if (!q.rw) begin
              unique case (q.addr)
                ADDR_CONFIG: d.res16 = wdata[RES_POS];
                ADDR_CRIT:   d.crit  = wdata;
                ADDR_HYST:   d.hyst  = wdata[HYST_BITS-1:0];
                ADDR_HIGH:   d.high  = wdata;
                ADDR_LOW:    d.low   = wdata;
                default:     d.phase = PH_SKIP;
              endcase
            end
          end
        end
        PH_SKIP: begin
          d.cnt = q.cnt;
        end
      endcase
      // the run of ones may span frames; a zero bit or the reset it fires clears it
      if (q.din_s2 && q.ones == ONES_LAST) begin
        iface_rst = 1'b1;
      end
    end else if (fall && q.phase == PH_DATA && q.rw) begin
      d.dout   = q.out_sh[15];
      d.out_sh = {q.out_sh[14:0], 1'b0};
    end

    // a new result outranks a read of the old one in the same cycle
    if (conv_valid) begin
      d.rdy = 1'b0;
      if (q.res16) begin
        d.result = sample;
      end else begin
        d.result = {sample[15:FLAG_BITS],
                    beyond[LIM_CRIT],
                    beyond[LIM_HIGH],
                    beyond[LIM_LOW]};
      end
    end

    // open-drain pins pull low while the alarm stands
    d.crit_oe = active[LIM_CRIT];
    d.int_oe  = active[LIM_HIGH] | active[LIM_LOW];
    // open-drain data level never leaves zero; only the enable moves
    d.crit_lvl = 1'b0;
    d.int_lvl  = 1'b0;

    if (iface_rst) begin
      // long run of ones restores every register to power-on state
      d = BANK_RST;
      d.sclk_s1 = sclk;
      d.sclk_s2 = q.sclk_s1;
      d.sclk_p  = q.sclk_s2;
      d.cs_s1   = cs_n;
      d.cs_s2   = q.cs_s1;
      d.din_s1  = din;
      d.din_s2  = q.din_s1;
      d.phase   = PH_SKIP;
      // keep the select view and data level so a frame in flight stays clean
      d.dout_oe = ~q.cs_s2;
      d.dout    = q.dout;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      q <= BANK_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign dout               = q.dout;
  assign dout_oe            = q.dout_oe;
  assign critical_alarm_oe  = q.crit_oe;
  assign int_oe             = q.int_oe;
  assign critical_alarm_out = q.crit_lvl;
  assign int_out            = q.int_lvl;

endmodule // temp_limit_register_bank

`default_nettype wire

// ==== test/temp_limit_chk.sv ====
// checker: pin and serial-port timing of the register bank
// assumes: bound to the top module, sys_clk domain only
`timescale 1ns/1ps
`default_nettype none
module temp_limit_chk (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic [15:0] conv_data,
  input wire logic        conv_valid,
  input wire logic        sclk,
  input wire logic        cs_n,
  input wire logic        din,
  input wire logic        dout,
  input wire logic        dout_oe,
  input wire logic        critical_alarm_out,
  input wire logic        critical_alarm_oe,
  input wire logic        int_out,
  input wire logic        int_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // sequences
  sequence s_sel_held;   !cs_n [*4];            endsequence
  sequence s_desel_held; cs_n [*4];             endsequence
  sequence s_bit_high;   (sclk && !cs_n) [*5];  endsequence
  sequence s_no_sample;  !conv_valid [*3];      endsequence
  // ==========================================================
  // assertions
  a_ct_open_drain: assert property (critical_alarm_out == 1'b0)
    else $error("critical pin level driven high");
  a_int_open_drain: assert property (int_out == 1'b0)
    else $error("interrupt pin level driven high");
  a_ct_from_conv: assert property ($changed(critical_alarm_oe) |-> $past(conv_valid, 2))
    else $error("critical pin moved without a sample");
  a_int_from_conv: assert property ($changed(int_oe) |-> $past(conv_valid, 2))
    else $error("interrupt pin moved without a sample");
  a_pins_quiet: assert property (s_no_sample |-> $stable(int_oe) && $stable(critical_alarm_oe))
    else $error("alarm pins moved between samples");
  a_oe_select: assert property (s_sel_held |-> dout_oe)
    else $error("data out not enabled while selected");
  a_oe_release: assert property (s_desel_held |-> !dout_oe)
    else $error("data out enabled while deselected");
  a_dout_hold: assert property (s_bit_high |-> $stable(dout))
    else $error("data out moved while clock high");
  c_neg_sample: cover property (conv_valid && conv_data[15]);
  c_one_bits: cover property (!cs_n && din);
endmodule // temp_limit_chk
`default_nettype wire

// ==== test/spi_host_model.sv ====
// host model: mode 3 frames, msb first, clock idles high
// assumes: device samples din on rising sclk, drives dout after falling sclk
`timescale 1ns/1ps
`default_nettype none
module spi_host_model #(
  parameter int HALF = 5
) (
  input  wire logic sys_clk,
  input  wire logic dout,
  input  wire logic dout_oe,
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic din
);
  // ==========================================================
  // frame engine
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  // five-cycle halves keep clear of the two-flop synchroniser lag
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    @(negedge sys_clk);
    cs_n = 1'b0;
    repeat (HALF) @(negedge sys_clk);
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      din  = tx[31-i];
      repeat (HALF) @(negedge sys_clk);
      rx   = {rx[30:0], dout_oe ? dout : ~dout};
      sclk = 1'b1;
      repeat (HALF) @(negedge sys_clk);
    end
    cs_n = 1'b1;
    din  = ~din;
    repeat (HALF) @(negedge sys_clk);
  endtask
endmodule // spi_host_model
`default_nettype wire

// ==== test/tb_temp_limit_register_bank.sv ====
// testbench: register map, conversion flags and alarm pins over the serial port
// assumes: host model drives the serial pins, bench drives the conversion port
`timescale 1ns/1ps
`default_nettype none
module tb_temp_limit_register_bank;
  import temp_limit_pkg::*;
  localparam logic [4:0] ID_MAKER = 5'h15; // arbitrary value
  localparam logic [2:0] ID_REV   = 3'h2;  // arbitrary value
  // sample, expected result word, expected {critical, interrupt} pins
  localparam logic [33:0] VEC [7] = '{{16'h1207, 16'h1202, 2'b01},
    {16'h1900, 16'h1906, 2'b11}, {16'h17c0, 16'h17c2, 2'b11}, {16'h1700, 16'h1702, 2'b01},
    {16'hfe00, 16'hfe01, 2'b01}, {16'h0840, 16'h0840, 2'b01}, {16'h0900, 16'h0900, 2'b00}};
  logic        sys_clk, rstn, conv_valid, sclk, cs_n, din, dout, dout_oe;
  logic        critical_alarm_out, critical_alarm_oe, int_out, int_oe;
  logic [15:0] conv_data;
  logic [31:0] rx;
  int          fail_count, checks_done;
  // ==========================================================
  // instances
  temp_limit_register_bank #(.MAKER_CODE(ID_MAKER), .REV_CODE(ID_REV), .ONES_RESET(32))
    u_temp_limit_register_bank (.sys_clk(sys_clk), .rstn(rstn), .conv_data(conv_data),
    .conv_valid(conv_valid), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .dout_oe(dout_oe), .critical_alarm_out(critical_alarm_out),
    .critical_alarm_oe(critical_alarm_oe), .int_out(int_out), .int_oe(int_oe));
  spi_host_model #(.HALF(5)) u_spi_host_model (.sys_clk(sys_clk), .dout(dout),
    .dout_oe(dout_oe), .sclk(sclk), .cs_n(cs_n), .din(din));
  // ==========================================================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic wide(input logic [2:0] a);
    return (a == ADDR_RESULT) || (a == ADDR_CRIT) || (a == ADDR_HIGH) || (a == ADDR_LOW);
  endfunction
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    logic [31:0] r;
    if (wide(a)) u_spi_host_model.xfer({2'b00, a, 3'b000, d, 8'h00}, 24, r);
    else u_spi_host_model.xfer({2'b00, a, 3'b000, d[7:0], 16'h0000}, 16, r);
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    logic [31:0] r;
    u_spi_host_model.xfer({2'b01, a, 3'b000, 24'h000000}, wide(a) ? 24 : 16, r);
    chk(wide(a) ? r[15:0] : {8'h00, r[7:0]}, exp);
  endtask
  task automatic conv(input logic [15:0] t);
    @(negedge sys_clk);
    conv_data  = t;
    conv_valid = 1'b1;
    @(negedge sys_clk);
    conv_valid = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // clock, watchdog, tests
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    #2_000_000;
    fail_count++;
    end_of_test();
  end
  initial begin
    rstn = 1'b0;
    conv_valid = 1'b0;
    conv_data = 16'h0000;
    fail_count = 0;
    checks_done = 0;
    repeat (2) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    rd(ADDR_RESULT, RESULT_RST);
    rd(ADDR_CRIT, CRIT_RST);
    rd(ADDR_HYST, {12'h000, HYST_RST});
    rd(ADDR_HIGH, HIGH_RST);
    rd(ADDR_LOW, LOW_RST);
    rd(ADDR_IDENT, {8'h00, ID_MAKER, ID_REV});
    rd(ADDR_STATUS, 16'h0080);
    rd(ADDR_CONFIG, 16'h0000);
    wr(ADDR_HYST, 16'h00ff);
    rd(ADDR_HYST, 16'h000f);
    wr(ADDR_IDENT, 16'h0000);
    rd(ADDR_IDENT, {8'h00, ID_MAKER, ID_REV});
    wr(ADDR_RESULT, 16'h7777);
    rd(ADDR_RESULT, 16'h0000);
    wr(ADDR_HIGH, 16'h1000);
    wr(ADDR_LOW, 16'h0800);
    wr(ADDR_CRIT, 16'h1800);
    wr(ADDR_HYST, 16'h0001);
    // low bits set: frame must be dropped whole
    u_spi_host_model.xfer(32'h31aaaa00, 24, rx);
    rd(ADDR_HIGH, 16'h1000);
    for (int i = 0; i < 7; i++) begin
      conv(VEC[i][33:18]);
      rd(ADDR_RESULT, VEC[i][17:2]);
      chk({14'h0000, critical_alarm_oe, int_oe}, {14'h0000, VEC[i][1:0]});
    end
    conv(16'h0a07);
    rd(ADDR_STATUS, 16'h0000);
    rd(ADDR_RESULT, 16'h0a00);
    rd(ADDR_STATUS, 16'h0080);
    wr(ADDR_CONFIG, 16'h0080);
    conv(16'h0a05);
    rd(ADDR_RESULT, 16'h0a05);
    rd(ADDR_CONFIG, 16'h0080);
    u_spi_host_model.xfer(32'hffffffff, 32, rx);
    repeat (10) @(negedge sys_clk);
    rd(ADDR_HIGH, HIGH_RST);
    rd(ADDR_CONFIG, 16'h0000);
    end_of_test();
  end
endmodule // tb_temp_limit_register_bank
bind temp_limit_register_bank temp_limit_chk u_temp_limit_chk (.sys_clk(sys_clk),
  .rstn(rstn), .conv_data(conv_data), .conv_valid(conv_valid), .sclk(sclk), .cs_n(cs_n),
  .din(din), .dout(dout), .dout_oe(dout_oe), .critical_alarm_out(critical_alarm_out),
  .critical_alarm_oe(critical_alarm_oe), .int_out(int_out), .int_oe(int_oe));
`default_nettype wire
